// ### mvwc_pkg.sv
// Package: shared constants and carriers for the MAC VLAN, wake-up and
// checksum configuration block.
// Assumes: one 40 MHz clock domain; APB register access with 32-bit data.
package mvwc_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [3:0] MVWC_IDX_FIRST_VLAN_TAG   = 4'h9;
  localparam logic [3:0] MVWC_IDX_SECOND_VLAN_TAG  = 4'hA;
  localparam logic [3:0] MVWC_IDX_WAKE_FILTER_PORT = 4'hB;
  localparam logic [3:0] MVWC_IDX_WAKE_CTRL_STAT   = 4'hC;
  localparam logic [3:0] MVWC_IDX_CSUM_CTRL        = 4'hD;
  localparam int unsigned MVWC_ADDR_W = 12;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int unsigned MVWC_TAG_W              = 16;
  localparam int unsigned MVWC_GU_WAKE_EN_BIT     = 9;
  localparam int unsigned MVWC_WAKE_FRAME_RX_BIT  = 6;
  localparam int unsigned MVWC_PATTERN_RX_BIT     = 5;
  localparam int unsigned MVWC_WAKE_FRAME_EN_BIT  = 2;
  localparam int unsigned MVWC_PATTERN_EN_BIT     = 1;
  localparam int unsigned MVWC_TX_CSUM_EN_BIT     = 16;
  localparam int unsigned MVWC_RX_CSUM_MODE_BIT   = 1;
  localparam int unsigned MVWC_RX_CSUM_EN_BIT     = 0;

  // ---------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------
  localparam logic [15:0] MVWC_RST_TAG  = 16'h0000;
  localparam logic        MVWC_RST_BIT  = 1'b0;
  localparam logic [31:0] MVWC_RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Frame geometry (byte positions counted from zero)
  // ---------------------------------------------------------------------
  localparam logic [15:0] MVWC_MAX_LEN_STD  = 16'h05EE; // 1518 bytes
  localparam logic [15:0] MVWC_MAX_LEN_VLAN = 16'h05F2; // 1522 bytes
  localparam logic [15:0] MVWC_HDR_FIRST    = 16'h000C; // 13th byte
  localparam int unsigned MVWC_HDR_BYTES    = 10;
  localparam logic [15:0] MVWC_HDR_LAST     = 16'h0015;
  localparam logic [7:0]  MVWC_CSUM_BASE    = 8'h0E;    // 14 bytes
  localparam logic [7:0]  MVWC_VLAN_ADD     = 8'h04;
  localparam logic [7:0]  MVWC_SNAP_ADD     = 8'h08;
  localparam logic [15:0] MVWC_MAX_LEN_FLD  = 16'h05DC;
  localparam logic [23:0] MVWC_SNAP_HDR     = 24'hAAAA03;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       good;
    logic [7:0] data;
  } mvwc_rx_s;

  typedef struct packed {
    logic                               done;
    logic                               good;
    logic                               ucast;
    logic [15:0]                        len;
    logic [MVWC_HDR_BYTES-1:0][7:0]     hdr;
  } mvwc_hdr_s;

  typedef enum logic [1:0] {
    MVWC_RX_IDLE = 2'b00,
    MVWC_RX_HDR  = 2'b01,
    MVWC_RX_BODY = 2'b11
  } mvwc_rx_state_e;

endpackage

// ### mvwc_rx_parse.sv
// Receive frame parser: counts bytes and keeps the header bytes that
// follow the destination and source addresses.
// Assumes: byte stream from the MAC receive path on the same clock.
`timescale 1ns/100ps
module mvwc_rx_parse
  import mvwc_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  // Receive stream
  input  wire mvwc_rx_s  i_rx,
  // Frame summary, one-cycle done
  output mvwc_hdr_s      o_hdr
);

  mvwc_rx_state_e                 st_q, st_d;
  logic [15:0]                    cnt_q, cnt_d;
  logic [15:0]                    len_q, len_d;
  logic [MVWC_HDR_BYTES-1:0][7:0] hdr_q, hdr_d;
  logic                           done_q, done_d;
  logic                           good_q, good_d;
  logic                           ucast_q, ucast_d;
  logic [15:0]                    pos;
  logic [15:0]                    off;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    hdr_d   = hdr_q;
    good_d  = good_q;
    ucast_d = ucast_q;
    done_d  = 1'b0;
    pos     = i_rx.sof ? 16'h0000 : cnt_q;
    off     = pos - MVWC_HDR_FIRST;
    if (i_rx.valid && (i_rx.sof || st_q != MVWC_RX_IDLE)) begin
      if (i_rx.sof) begin
        // Group bit of the destination address
        ucast_d = ~i_rx.data[0];
        hdr_d   = '0;
        st_d    = MVWC_RX_HDR;
      end
      if (pos >= MVWC_HDR_FIRST && pos <= MVWC_HDR_LAST) begin
        hdr_d[off[3:0]] = i_rx.data;
      end
      if (pos == MVWC_HDR_LAST) begin
        st_d = MVWC_RX_BODY;
      end
      // Saturates so oversize frames still read as too long
      cnt_d = (pos == 16'hFFFF) ? pos : pos + 16'h0001;
      if (i_rx.eof) begin
        done_d = 1'b1;
        len_d  = cnt_d;
        good_d = i_rx.good;
        st_d   = MVWC_RX_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q    <= MVWC_RX_IDLE;
      cnt_q   <= 16'h0000;
      len_q   <= 16'h0000;
      hdr_q   <= '0;
      done_q  <= 1'b0;
      good_q  <= 1'b0;
      ucast_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      hdr_q   <= hdr_d;
      done_q  <= done_d;
      good_q  <= good_d;
      ucast_q <= ucast_d;
    end
  end

  assign o_hdr = '{done: done_q, good: good_q, ucast: ucast_q,
                   len: len_q, hdr: hdr_q};

endmodule

// ### mvwc_wake_filter.sv
// Wake-up frame filter store: indexed, write-only entries loaded through
// one port whose internal pointer steps and wraps.
// Assumes: write pulse already qualified by the register decoder.
`timescale 1ns/100ps
module mvwc_wake_filter #(
  parameter int unsigned ENTRIES = 8,
  parameter int unsigned WIDTH   = 32
) (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  // Write port
  input  wire logic                          i_wr,
  input  wire logic [WIDTH-1:0]              i_wdata,
  input  wire logic [WIDTH/8-1:0]            i_strb,
  // Filter contents and pointer
  output logic [ENTRIES-1:0][WIDTH-1:0]      o_entries,
  output logic [$clog2(ENTRIES)-1:0]         o_ptr
);

  localparam int unsigned PW = $clog2(ENTRIES);
  localparam logic [PW-1:0] PTR_LAST = PW'(ENTRIES - 1);

  logic [ENTRIES-1:0][WIDTH-1:0] ent_q, ent_d;
  logic [PW-1:0]                 ptr_q, ptr_d;

  always_comb begin
    ent_d = ent_q;
    ptr_d = ptr_q;
    if (i_wr) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (i_strb[b]) begin
          ent_d[ptr_q][b*8 +: 8] = i_wdata[b*8 +: 8];
        end
      end
      // Steps to the next entry, back to entry zero after the last
      ptr_d = (ptr_q == PTR_LAST) ? '0 : ptr_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ent_q <= '0;
      ptr_q <= '0;
    end else begin
      ent_q <= ent_d;
      ptr_q <= ptr_d;
    end
  end

  assign o_entries = ent_q;
  assign o_ptr     = ptr_q;

endmodule

// ### mvwc_mac_cfg.sv
// MAC VLAN detection, wake-up configuration and checksum offload control,
// with an APB register slave.
// Assumes: receive stream and wake matcher on i_clk; software keeps the
// usage limits on the tag and checksum fields.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module mvwc_mac_cfg
  import mvwc_pkg::*;
#(
  parameter int unsigned FILTER_ENTRIES = 8
) (
  // Clock and resets
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_soft_rst,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [MVWC_ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]             i_pwdata,
  input  wire logic [3:0]              i_pstrb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // Receive stream and wake matcher results
  input  wire mvwc_rx_s                i_rx,
  input  wire logic                    i_wake_frame_hit,
  input  wire logic                    i_pattern_hit,
  // Frame classification
  output logic                         o_frame_done,
  output logic                         o_first_vlan_tag_hit,
  output logic                         o_second_vlan_tag_hit,
  output logic [15:0]                  o_max_len,
  output logic                         o_len_err,
  // Wake-up
  output logic                         o_wake_event,
  output logic                         o_wake_frame_enable,
  output logic                         o_wake_pattern_packet_enable,
  output logic [FILTER_ENTRIES-1:0][31:0] o_wake_filter_word,
  // Checksum engines
  output logic                         o_tx_checksum_enable,
  output logic                         o_rx_checksum_enable,
  output logic                         o_rx_checksum_start_mode,
  output logic [7:0]                   o_rx_csum_start
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Returns {hit, index}; only aligned words 9..13 hit
  function automatic logic [4:0] mvwc_decode(input logic [MVWC_ADDR_W-1:0] a);
    logic [3:0] idx;
    logic       hit;
    idx = a[5:2];
    hit = (a[MVWC_ADDR_W-1:6] == '0) && (a[1:0] == 2'b00) &&
          (idx >= MVWC_IDX_FIRST_VLAN_TAG) && (idx <= MVWC_IDX_CSUM_CTRL);
    return {hit, idx};
  endfunction

  function automatic logic [31:0] mvwc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------------
  logic        rst;
  logic [15:0] tag1_q, tag1_d;
  logic [15:0] tag2_q, tag2_d;
  logic        gu_en_q, gu_en_d;
  logic        wf_en_q, wf_en_d;
  logic        pp_en_q, pp_en_d;
  logic        wf_rx_q, wf_rx_d;
  logic        pp_rx_q, pp_rx_d;
  logic        tx_cs_q, tx_cs_d;
  logic        rx_cs_q, rx_cs_d;
  logic        rx_md_q, rx_md_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [4:0]  dec;
  logic        commit;
  logic        wr_hit;
  logic        filt_wr;
  logic [31:0] merged;
  logic        wf_set;
  logic        pp_set;

  // Soft reset acts like the hardware reset on this block
  assign rst     = i_rst | i_soft_rst;
  assign dec     = mvwc_decode(i_paddr);
  // Writes land only at the edge where pready is seen high
  assign commit  = i_psel & i_penable & pready_q;
  assign wr_hit  = commit & i_pwrite & dec[4];
  assign filt_wr = wr_hit && (dec[3:0] == MVWC_IDX_WAKE_FILTER_PORT);
  assign wf_set  = i_wake_frame_hit & wf_en_q;
  assign pp_set  = i_pattern_hit & pp_en_q;

  // -----------------------------------------------------------------------
  // APB access and register next state
  // -----------------------------------------------------------------------
  always_comb begin
    tag1_d    = tag1_q;
    tag2_d    = tag2_q;
    gu_en_d   = gu_en_q;
    wf_en_d   = wf_en_q;
    pp_en_d   = pp_en_q;
    tx_cs_d   = tx_cs_q;
    rx_cs_d   = rx_cs_q;
    rx_md_d   = rx_md_q;
    merged    = 32'h0000_0000;
    // One wait state: answer registered in the first access cycle
    pready_d  = i_psel & i_penable & ~pready_q;
    pslverr_d = i_psel & i_penable & ~pready_q & ~dec[4];
    prdata_d  = 32'h0000_0000;
    if (i_psel && i_penable && !pready_q && !i_pwrite && dec[4]) begin
      case (dec[3:0])
        MVWC_IDX_FIRST_VLAN_TAG:  prdata_d = {16'h0000, tag1_q};
        MVWC_IDX_SECOND_VLAN_TAG: prdata_d = {16'h0000, tag2_q};
        MVWC_IDX_WAKE_FILTER_PORT: prdata_d = 32'h0000_0000;
        MVWC_IDX_WAKE_CTRL_STAT: begin
          prdata_d[MVWC_GU_WAKE_EN_BIT]    = gu_en_q;
          prdata_d[MVWC_WAKE_FRAME_RX_BIT] = wf_rx_q;
          prdata_d[MVWC_PATTERN_RX_BIT]    = pp_rx_q;
          prdata_d[MVWC_WAKE_FRAME_EN_BIT] = wf_en_q;
          prdata_d[MVWC_PATTERN_EN_BIT]    = pp_en_q;
        end
        MVWC_IDX_CSUM_CTRL: begin
          prdata_d[MVWC_TX_CSUM_EN_BIT]   = tx_cs_q;
          prdata_d[MVWC_RX_CSUM_MODE_BIT] = rx_md_q;
          prdata_d[MVWC_RX_CSUM_EN_BIT]   = rx_cs_q;
        end
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_hit) begin
      case (dec[3:0])
        MVWC_IDX_FIRST_VLAN_TAG: begin
          merged = mvwc_merge({16'h0000, tag1_q}, i_pwdata, i_pstrb);
          tag1_d = merged[15:0];
        end
        MVWC_IDX_SECOND_VLAN_TAG: begin
          merged = mvwc_merge({16'h0000, tag2_q}, i_pwdata, i_pstrb);
          tag2_d = merged[15:0];
        end
        MVWC_IDX_WAKE_CTRL_STAT: begin
          if (i_pstrb[1]) begin
            gu_en_d = i_pwdata[MVWC_GU_WAKE_EN_BIT];
          end
          if (i_pstrb[0]) begin
            wf_en_d = i_pwdata[MVWC_WAKE_FRAME_EN_BIT];
            pp_en_d = i_pwdata[MVWC_PATTERN_EN_BIT];
          end
        end
        MVWC_IDX_CSUM_CTRL: begin
          if (i_pstrb[2]) begin
            tx_cs_d = i_pwdata[MVWC_TX_CSUM_EN_BIT];
          end
          if (i_pstrb[0]) begin
            rx_md_d = i_pwdata[MVWC_RX_CSUM_MODE_BIT];
            rx_cs_d = i_pwdata[MVWC_RX_CSUM_EN_BIT];
          end
        end
        default: merged = 32'h0000_0000;
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle wins
    wf_rx_d = wf_set | (wf_rx_q & ~(wr_hit && i_pstrb[0] &&
              dec[3:0] == MVWC_IDX_WAKE_CTRL_STAT &&
              i_pwdata[MVWC_WAKE_FRAME_RX_BIT]));
    pp_rx_d = pp_set | (pp_rx_q & ~(wr_hit && i_pstrb[0] &&
              dec[3:0] == MVWC_IDX_WAKE_CTRL_STAT &&
              i_pwdata[MVWC_PATTERN_RX_BIT]));
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      tag1_q    <= MVWC_RST_TAG;
      tag2_q    <= MVWC_RST_TAG;
      gu_en_q   <= MVWC_RST_BIT;
      wf_en_q   <= MVWC_RST_BIT;
      pp_en_q   <= MVWC_RST_BIT;
      wf_rx_q   <= MVWC_RST_BIT;
      pp_rx_q   <= MVWC_RST_BIT;
      tx_cs_q   <= MVWC_RST_BIT;
      rx_cs_q   <= MVWC_RST_BIT;
      rx_md_q   <= MVWC_RST_BIT;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= MVWC_RST_WORD;
    end else begin
      tag1_q    <= tag1_d;
      tag2_q    <= tag2_d;
      gu_en_q   <= gu_en_d;
      wf_en_q   <= wf_en_d;
      pp_en_q   <= pp_en_d;
      wf_rx_q   <= wf_rx_d;
      pp_rx_q   <= pp_rx_d;
      tx_cs_q   <= tx_cs_d;
      rx_cs_q   <= rx_cs_d;
      rx_md_q   <= rx_md_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // -----------------------------------------------------------------------
  // Wake-up filter store and frame parser
  // -----------------------------------------------------------------------
  mvwc_hdr_s hdr;

  mvwc_wake_filter #(
    .ENTRIES (FILTER_ENTRIES),
    .WIDTH   (32)
  ) u_filter (
    .i_clk     (i_clk),
    .i_rst     (rst),
    .i_wr      (filt_wr),
    .i_wdata   (i_pwdata),
    .i_strb    (i_pstrb),
    .o_entries (o_wake_filter_word),
    .o_ptr     ()
  );

  mvwc_rx_parse u_parse (
    .i_clk (i_clk),
    .i_rst (rst),
    .i_rx  (i_rx),
    .o_hdr (hdr)
  );

  // -----------------------------------------------------------------------
  // Frame classification and wake events
  // -----------------------------------------------------------------------
  logic        done_q;
  logic        v1_q, v1_d;
  logic        v2_q, v2_d;
  logic [15:0] max_q, max_d;
  logic        lerr_q;
  logic        wake_q, wake_d;
  logic [7:0]  start_q, start_d;
  logic [15:0] tag_fld;
  logic [15:0] type_fld;
  logic [23:0] snap_fld;
  logic        is_vlan;
  logic        is_snap;

  always_comb begin
    v1_d     = v1_q;
    v2_d     = v2_q;
    max_d    = max_q;
    start_d  = start_q;
    tag_fld  = {hdr.hdr[0], hdr.hdr[1]};
    v1_d     = hdr.done ? (tag_fld == tag1_q) : v1_q;
    v2_d     = hdr.done ? (tag_fld == tag2_q) : v2_q;
    is_vlan  = (tag_fld == tag1_q) || (tag_fld == tag2_q);
    // Past a tag the type field and any SNAP header move four bytes on
    type_fld = is_vlan ? {hdr.hdr[4], hdr.hdr[5]} : tag_fld;
    snap_fld = is_vlan ? {hdr.hdr[6], hdr.hdr[7], hdr.hdr[8]}
                       : {hdr.hdr[2], hdr.hdr[3], hdr.hdr[4]};
    is_snap  = (type_fld <= MVWC_MAX_LEN_FLD) && (snap_fld == MVWC_SNAP_HDR);
    if (hdr.done) begin
      max_d   = is_vlan ? MVWC_MAX_LEN_VLAN : MVWC_MAX_LEN_STD;
      start_d = MVWC_CSUM_BASE;
      if (rx_md_q) begin
        start_d = MVWC_CSUM_BASE + (is_vlan ? MVWC_VLAN_ADD : 8'h00) +
                  (is_snap ? MVWC_SNAP_ADD : 8'h00);
      end
    end
    wake_d = wf_set | pp_set |
             (hdr.done & hdr.good & hdr.ucast & gu_en_q);
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      done_q  <= 1'b0;
      v1_q    <= 1'b0;
      v2_q    <= 1'b0;
      max_q   <= MVWC_MAX_LEN_STD;
      lerr_q  <= 1'b0;
      wake_q  <= 1'b0;
      start_q <= MVWC_CSUM_BASE;
    end else begin
      done_q  <= hdr.done;
      v1_q    <= v1_d;
      v2_q    <= v2_d;
      max_q   <= max_d;
      lerr_q  <= hdr.done && (hdr.len > max_d);
      wake_q  <= wake_d;
      start_q <= start_d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // -----------------------------------------------------------------------
  assign o_prdata                     = prdata_q;
  assign o_pready                     = pready_q;
  assign o_pslverr                    = pslverr_q;
  assign o_frame_done                 = done_q;
  assign o_first_vlan_tag_hit                  = v1_q;
  assign o_second_vlan_tag_hit                  = v2_q;
  assign o_max_len                    = max_q;
  assign o_len_err                    = lerr_q;
  assign o_wake_event                 = wake_q;
  assign o_wake_frame_enable          = wf_en_q;
  assign o_wake_pattern_packet_enable = pp_en_q;
  // Engines sample these levels; software keeps them steady while busy
  assign o_tx_checksum_enable         = tx_cs_q;
  assign o_rx_checksum_enable         = rx_cs_q;
  assign o_rx_checksum_start_mode     = rx_md_q;
  assign o_rx_csum_start              = start_q;

endmodule

// ### mvwc_frame_src.sv
// Frame source standing in for the network side of the receive path.
// Assumes: send() is called just after a rising edge of i_clk.
`timescale 1ns/100ps
module mvwc_frame_src
  import mvwc_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Receive stream
  output mvwc_rx_s  o_rx
);
  initial o_rx = '0;

  // Byte 0 destination, bytes 12-13 tag, rest a running count
  task automatic send(input logic [15:0] n, tg, input logic [7:0] d0);
    logic [7:0] b;
    @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      b = k == 0 ? d0 : k == 12 ? tg[15:8] : k == 13 ? tg[7:0] : k[7:0];
      o_rx <= '{1'b1, k == 0, k == n - 1, 1'b1, b};
      @(posedge i_clk);
    end
    // Idle line shows no stale byte
    o_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~b};
  endtask
endmodule

// ### mvwc_mac_cfg_chk.sv
// Checker: port-level timing of the MAC configuration block.
// Assumes: bound to mvwc_mac_cfg; one clock, synchronous resets.
`timescale 1ns/100ps
module mvwc_mac_cfg_chk
  import mvwc_pkg::*;
#(
  parameter int unsigned FILTER_ENTRIES = 8
) (
  // Clock, resets, APB
  input wire logic                            i_clk,
  input wire logic                            i_rst,
  input wire logic                            i_soft_rst,
  input wire logic                            i_psel,
  input wire logic                            i_penable,
  input wire logic                            i_pwrite,
  input wire logic [MVWC_ADDR_W-1:0]          i_paddr,
  input wire logic [31:0]                     o_prdata,
  input wire logic                            o_pready,
  input wire logic                            o_pslverr,
  // Wake and frame
  input wire logic                            i_wake_frame_hit,
  input wire logic                            i_pattern_hit,
  input wire logic                            o_frame_done,
  input wire logic                            o_first_vlan_tag_hit,
  input wire logic                            o_second_vlan_tag_hit,
  input wire logic [15:0]                     o_max_len,
  input wire logic                            o_wake_event,
  input wire logic                            o_wake_frame_enable,
  input wire logic                            o_wake_pattern_packet_enable,
  input wire logic [FILTER_ENTRIES-1:0][31:0] o_wake_filter_word,
  input wire logic                            o_tx_checksum_enable,
  input wire logic                            o_rx_checksum_start_mode,
  input wire logic [7:0]                      o_rx_csum_start
);
  wire logic rst = i_rst | i_soft_rst;
  wire logic wr  = i_psel & i_penable & o_pready & i_pwrite;
  wire logic vl  = o_first_vlan_tag_hit | o_second_vlan_tag_hit;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);

  property p_wf_wake; i_wake_frame_hit && o_wake_frame_enable
    |=> o_wake_event; endproperty
  a_wf_wake: assert property (p_wf_wake) else $error("no wake");
  property p_pat_wake; i_pattern_hit && o_wake_pattern_packet_enable
    |=> o_wake_event; endproperty
  a_pat_wake: assert property (p_pat_wake) else $error("no wake");
  property p_len; o_frame_done |->
    o_max_len == (vl ? MVWC_MAX_LEN_VLAN : MVWC_MAX_LEN_STD); endproperty
  a_len: assert property (p_len) else $error("bad max length");
  property p_st0; o_frame_done && !o_rx_checksum_start_mode
    |-> o_rx_csum_start == MVWC_CSUM_BASE; endproperty
  a_st0: assert property (p_st0) else $error("bad start");
  property p_st1; o_frame_done && o_rx_checksum_start_mode && vl
    |-> o_rx_csum_start inside {8'h12, 8'h1A}; endproperty
  a_st1: assert property (p_st1) else $error("bad l3 start");
  property p_fw; $changed(o_wake_filter_word)
    |-> $past(wr && i_paddr == 12'h02C) || $past(rst); endproperty
  a_fw: assert property (p_fw) else $error("stray filter change");
  property p_tx; $changed(o_tx_checksum_enable)
    |-> $past(wr && i_paddr == 12'h034) || $past(rst); endproperty
  a_tx: assert property (p_tx) else $error("stray tx enable");
  property p_fr; i_psel && !i_pwrite && i_paddr == 12'h02C && o_pready
    |-> o_prdata == 32'h0; endproperty
  a_fr: assert property (p_fr) else $error("filter readable");

  c_vlan: cover property (o_frame_done && o_first_vlan_tag_hit);
  c_err: cover property (o_pslverr);
  c_wake: cover property (o_wake_event);
endmodule

// ### tb_mac_vlan_wakeup_checksum_cfg.sv
// Testbench: APB registers, frame classification, wake-up and filter.
// Assumes: package, design, frame source and checker compiled first.
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t %0h %0h", $time, (a), (e)); end end
`define RD(a, e) begin apb(1'b0, a, 32'h0); `CHK(rd, e) end
module tb_mac_vlan_wakeup_checksum_cfg
  import mvwc_pkg::*;
();
  logic i_clk, i_rst, i_soft_rst, i_psel, i_penable, i_pwrite, se;
  logic i_wake_frame_hit, i_pattern_hit, o_pready, o_pslverr, o_len_err;
  logic o_frame_done, o_first_vlan_tag_hit, o_second_vlan_tag_hit, o_wake_event;
  logic o_wake_frame_enable, o_wake_pattern_packet_enable;
  logic o_tx_checksum_enable, o_rx_checksum_enable;
  logic o_rx_checksum_start_mode;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0] i_pstrb;
  logic [15:0] o_max_len, mx;
  logic [7:0] o_rx_csum_start, st;
  logic [7:0][31:0] o_wake_filter_word;
  mvwc_rx_s i_rx;
  int n_errors, n_checks;
  typedef struct packed {
    logic [15:0] t1, t2, ft, len;
    logic        md, v1, v2;
  } mvwc_row_s;
  // Used tag registers hold 0x8100
  mvwc_row_s rows [5] = '{
    '{16'h8100, 16'h0000, 16'h8100, 16'h05F2, 1'b1, 1'b1, 1'b0},
    '{16'h0000, 16'h8100, 16'h8100, 16'h05F3, 1'b0, 1'b0, 1'b1},
    '{16'h8100, 16'h8100, 16'h0800, 16'h05EE, 1'b1, 1'b0, 1'b0},
    '{16'h8100, 16'h8100, 16'h0800, 16'h05EF, 1'b0, 1'b0, 1'b0},
    '{16'h8100, 16'h8100, 16'h8100, 16'h0040, 1'b1, 1'b1, 1'b1}};
  logic [11:0] ra [5] = '{12'h024, 12'h028, 12'h030, 12'h034, 12'h038};
  logic [31:0] re [5] = '{32'h0000FFFF, 32'h0000FFFF, 32'h00000206,
                          32'h00010003, 32'h00000000};

  mvwc_mac_cfg i_mvwc_mac_cfg (.*);
  mvwc_frame_src i_mvwc_frame_src (.i_clk(i_clk), .o_rx(i_rx));

  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 20 && o_pready !== 1'b1; k++) @(posedge i_clk);
    if (k == 20) begin n_errors++; tally_and_finish(); end
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 40 && o_frame_done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    if (k == 40) begin n_errors++; tally_and_finish(); end
  endtask

  task automatic hit(input logic pat, input logic exp);
    @(posedge i_clk);
    i_wake_frame_hit <= !pat;
    i_pattern_hit <= pat;
    @(posedge i_clk);
    i_wake_frame_hit <= 1'b0;
    i_pattern_hit <= 1'b0;
    #1;
    `CHK(o_wake_event, exp)
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    {i_rst, i_soft_rst, i_psel, i_penable, i_pwrite} = 5'h10;
    {i_wake_frame_hit, i_pattern_hit, i_paddr, i_pwdata} = '0;
    i_pstrb = 4'hF;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, 12'h024, {16'h0, rows[i].t1});
      apb(1'b1, 12'h028, {16'h0, rows[i].t2});
      // Mode set with no frame in flight
      apb(1'b1, 12'h034,
          {15'h0, 1'b1, 14'h0, rows[i].md, 1'b1});
      i_mvwc_frame_src.send(rows[i].len, rows[i].ft, 8'h01);
      wait_done();
      mx = (rows[i].v1 | rows[i].v2) ? MVWC_MAX_LEN_VLAN : MVWC_MAX_LEN_STD;
      st = MVWC_CSUM_BASE +
           ((rows[i].md & (rows[i].v1 | rows[i].v2)) ? MVWC_VLAN_ADD : 8'h0);
      `CHK(o_first_vlan_tag_hit, rows[i].v1)
      `CHK(o_second_vlan_tag_hit, rows[i].v2)
      `CHK(o_max_len, mx)
      `CHK(o_len_err, rows[i].len > mx)
      `CHK(o_rx_csum_start, st)
    end
    for (int i = 0; i < 9; i++) apb(1'b1, 12'h02C, 32'hA5A50000 + i);
    #1;
    for (int i = 1; i < 8; i++)
      `CHK(o_wake_filter_word[i], 32'hA5A50000 + i)
    `CHK(o_wake_filter_word[0], 32'hA5A50008)
    `RD(12'h02C, 32'h0)
    apb(1'b1, 12'h030, 32'h00000206);
    hit(1'b0, 1'b1);
    `RD(12'h030, 32'h00000246)
    hit(1'b1, 1'b1);
    `RD(12'h030, 32'h00000266)
    apb(1'b1, 12'h030, 32'h00000260);
    `RD(12'h030, 32'h00000200)
    hit(1'b0, 1'b0);
    hit(1'b1, 1'b0);
    i_mvwc_frame_src.send(16'h0040, 16'h0800, 8'h02);
    wait_done();
    `CHK(o_wake_event, 1'b1)
    i_mvwc_frame_src.send(16'h0040, 16'h0800, 8'h03);
    wait_done();
    `CHK(o_wake_event, 1'b0)
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ra[i], 32'hFFFFFFFF);
      `RD(ra[i], re[i])
      `CHK(se, i == 4)
    end
    `CHK(o_tx_checksum_enable, 1'b1)
    `CHK(o_rx_checksum_enable, 1'b1)
    `CHK(o_wake_frame_enable, 1'b1)
    `CHK(o_wake_pattern_packet_enable, 1'b1)
    `CHK(o_rx_checksum_start_mode, 1'b1)
    @(posedge i_clk);
    i_soft_rst <= 1'b1;
    @(posedge i_clk);
    i_soft_rst <= 1'b0;
    for (int i = 0; i < 5; i++) `RD(ra[i], 32'h0)
    `CHK(o_tx_checksum_enable, 1'b0)
    apb(1'b1, 12'h02C, 32'h12345678);
    #1;
    `CHK(o_wake_filter_word[0], 32'h12345678)
    `CHK(o_wake_filter_word[1], 32'h0)
    tally_and_finish();
  end
endmodule

bind mvwc_mac_cfg mvwc_mac_cfg_chk #(.FILTER_ENTRIES(FILTER_ENTRIES))
  i_mvwc_mac_cfg_chk (.*);
